// file: core/prg_stage.sv
// four programmable compare stages with setting groups, force flag,
// counters and fault records, behind an AHB-Lite slave.
// assumes i_tick is a one-cycle task-interval pulse and the signal,
// date and time inputs are synchronous to i_clk.
// Operation
// - four setting groups, exactly one active
// - group changed by input, virtual or manually
// - selectable source decides the active group
// - four stages with independent settings
// - idle/blocked/start/trip, start and trip forcible only under force
// - start counter counts starts, clearable
// - trip counter counts trips, clearable
// - common force flag self-clears after five minutes
// - over, under, difference, absolute difference modes
// - under mode ignores values below floor
// - pickup in pu, primary equivalent readable
// - trip after pickup persists for delay
// - eight latest faults recorded per stage
// - elapsed delay as percent, 100 means trip or a zero delay
// - record holds the active group
// - record holds date and millisecond time
// - signal identity and value readable
//
// Implementation choices: the address map and the AHB-Lite register port.
`include "prg_stage_consts.svh"
module prg_stage #(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int FORCE_MS = `FORCE_MS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_tick,
  input wire logic [63:0] i_sig_a,
  input wire logic [63:0] i_sig_b,
  input wire logic [3:0] i_block,
  input wire logic [7:0] i_digital_input_n,
  input wire logic [7:0] i_virtual_input_n,
  input wire logic [7:0] i_indicator_signal_n,
  input wire logic [7:0] i_virtual_output_n,
  input wire logic [31:0] i_date,
  input wire logic [31:0] i_tod_ms,
  output logic [3:0] o_start,
  output logic [3:0] o_trip,
  output logic [1:0] o_active_group,
  output logic o_force
);
  // ==========================================================
  // bus slave: one wait state, read data registered in it
  logic dp_reg, dp_next, wait_reg, wait_next, dwr_reg, dwr_next;
  logic [11:0] da_reg, da_next;
  logic [31:0] rd_reg, rd_next, rd_val;
  logic we;
  always_comb begin
    dp_next = dp_reg;
    wait_next = wait_reg;
    dwr_next = dwr_reg;
    da_next = da_reg;
    rd_next = rd_reg;
    if (dp_reg && !wait_reg) begin
      wait_next = 1'b1;
      rd_next = dwr_reg ? 32'h0000_0000 : rd_val;
    end else if (dp_reg) begin
      dp_next = 1'b0;
    end
    if (i_hsel && i_htrans[1] && i_hready) begin
      dp_next = 1'b1;
      wait_next = 1'b0;
      dwr_next = i_hwrite;
      da_next = i_haddr[11:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dp_reg <= 1'b0;
      wait_reg <= 1'b0;
      dwr_reg <= 1'b0;
      da_reg <= 12'h000;
      rd_reg <= 32'h0000_0000;
    end else begin
      dp_reg <= dp_next;
      wait_reg <= wait_next;
      dwr_reg <= dwr_next;
      da_reg <= da_next;
      rd_reg <= rd_next;
    end
  end
  assign o_hreadyout = !dp_reg || wait_reg;
  assign o_hresp = 1'b0;
  assign o_hrdata = rd_reg;
  assign we = dp_reg && wait_reg && dwr_reg;
  logic glb;
  logic [1:0] sa;
  logic [7:0] so;
  assign glb = da_reg[10];
  assign sa = da_reg[9:8];
  assign so = da_reg[7:0];
  // ==========================================================
  // settings memory, written only by software
  prg_stage_pkg::group_setting_t set_m [`N_STAGE][`N_GROUP];
  logic [7:0] link_reg [`N_STAGE];
  logic [15:0] scale_reg [`N_STAGE];
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int s = 0; s < `N_STAGE; s++) begin
        link_reg[s] <= 8'h00;
        scale_reg[s] <= `RST_SCALE;
        for (int g = 0; g < `N_GROUP; g++) begin
          set_m[s][g] <= '{prg_stage_pkg::CMP_OVER, `RST_HYST, `RST_PICKUP,
                           `RST_FLOOR, `RST_DELAY};
        end
      end
    end else if (we && !glb) begin
      if (so == `A_LINK) begin
        link_reg[sa] <= i_hwdata[7:0];
      end else if (so == `A_PRI_SCALE) begin
        scale_reg[sa] <= i_hwdata[15:0];
      end else if (so[7:6] == `F_SETTING) begin
        case (so[3:2])
          2'd0: begin
            set_m[sa][so[5:4]].mode <=
              prg_stage_pkg::cmp_mode_t'(i_hwdata[1:0]);
            set_m[sa][so[5:4]].hyst_pct <= i_hwdata[`HYST_LSB +: 8];
          end
          2'd1: set_m[sa][so[5:4]].pickup <= i_hwdata[15:0];
          2'd2: set_m[sa][so[5:4]].under_mode_floor <= i_hwdata[15:0];
          default: set_m[sa][so[5:4]].delay_ticks <= i_hwdata[15:0];
        endcase
      end
    end
  end
  // ==========================================================
  // active group selection and force flag
  logic [1:0] man_grp_reg, man_grp_next, alt_grp_reg, alt_grp_next;
  logic [1:0] grp_reg, grp_next;
  prg_stage_pkg::group_src_t src_reg, src_next;
  logic [2:0] src_idx_reg, src_idx_next;
  logic force_reg, force_next;
  logic [31:0] div_reg, div_next, ms_reg, ms_next;
  logic sel_bit;
  always_comb begin
    man_grp_next = man_grp_reg;
    alt_grp_next = alt_grp_reg;
    src_next = src_reg;
    src_idx_next = src_idx_reg;
    force_next = force_reg;
    div_next = div_reg;
    ms_next = ms_reg;
    case (src_reg)
      prg_stage_pkg::SRC_DIGITAL: sel_bit = i_digital_input_n[src_idx_reg];
      prg_stage_pkg::SRC_VIRTUAL_IN: sel_bit = i_virtual_input_n[src_idx_reg];
      prg_stage_pkg::SRC_INDICATOR:
        sel_bit = i_indicator_signal_n[src_idx_reg];
      prg_stage_pkg::SRC_VIRTUAL_OUT:
        sel_bit = i_virtual_output_n[src_idx_reg];
      default: sel_bit = 1'b0;
    endcase
    grp_next = sel_bit ? alt_grp_reg : man_grp_reg;
    // millisecond enable, then count to the timeout
    if (force_reg) begin
      if (div_reg == 32'(MS_CYCLES - 1)) begin
        div_next = 32'h0000_0000;
        if (ms_reg == 32'(FORCE_MS - 1)) begin
          force_next = 1'b0;
        end else begin
          ms_next = ms_reg + 32'h0000_0001;
        end
      end else begin
        div_next = div_reg + 32'h0000_0001;
      end
    end
    if (we && glb) begin
      if (so == `A_ACT_GROUP) begin
        man_grp_next = i_hwdata[1:0];
        alt_grp_next = i_hwdata[`ALT_GRP_LSB +: 2];
      end else if (so == `A_GRP_SRC) begin
        src_next = prg_stage_pkg::group_src_t'(i_hwdata[`SRC_KIND_LSB +: 3]);
        src_idx_next = i_hwdata[2:0];
      end else if (so == `A_FORCE) begin
        // a set on the timeout cycle wins and restarts the timer
        force_next = i_hwdata[0];
        div_next = 32'h0000_0000;
        ms_next = 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      man_grp_reg <= 2'b00;
      alt_grp_reg <= 2'b01;
      grp_reg <= 2'b00;
      src_reg <= prg_stage_pkg::SRC_NONE;
      src_idx_reg <= 3'b000;
      force_reg <= 1'b0;
      div_reg <= 32'h0000_0000;
      ms_reg <= 32'h0000_0000;
    end else begin
      man_grp_reg <= man_grp_next;
      alt_grp_reg <= alt_grp_next;
      grp_reg <= grp_next;
      src_reg <= src_next;
      src_idx_reg <= src_idx_next;
      force_reg <= force_next;
      div_reg <= div_next;
      ms_reg <= ms_next;
    end
  end
  assign o_active_group = grp_reg;
  assign o_force = force_reg;
  // ==========================================================
  // the stages
  prg_stage_pkg::stage_state_t st_reg [`N_STAGE];
  logic [31:0] sc_reg [`N_STAGE];
  logic [31:0] tc_reg [`N_STAGE];
  prg_stage_pkg::fault_record_t rec_m [`N_STAGE][`N_REC];
  for (genvar s = 0; s < `N_STAGE; s++) begin : g_stage
    prg_stage_pkg::group_setting_t cfg;
    prg_stage_pkg::stage_state_t st_next;
    logic [15:0] a, b, el_reg, el_next, ext_reg, ext_next;
    logic signed [17:0] metric, pick, band;
    logic on, hold, sinc, tinc, rwe, wsel;
    logic [31:0] sc_next, tc_next;
    logic [7:0] pct;
    logic [2:0] wp_reg;
    assign cfg = set_m[s][grp_reg];
    assign a = i_sig_a[16*s +: 16];
    assign b = i_sig_b[16*s +: 16];
    assign wsel = we && !glb && sa == 2'(s);
    always_comb begin
      case (cfg.mode)
        prg_stage_pkg::CMP_DIFF: metric = $signed({2'b00, a}) -
                                           $signed({2'b00, b});
        prg_stage_pkg::CMP_MAGNITUDE_DIFFERENCE:
          metric = (a >= b) ? $signed({2'b00, a - b})
                            : $signed({2'b00, b - a});
        default: metric = $signed({2'b00, a});
      endcase
      pick = $signed({2'b00, cfg.pickup});
      band = $signed({2'b00, 16'((24'(cfg.pickup) * 24'(cfg.hyst_pct))
                                / 24'(`PCT_FULL))});
      if (cfg.mode == prg_stage_pkg::CMP_UNDER) begin
        // below the floor nothing counts as a fault
        on = a >= cfg.under_mode_floor && metric < pick;
        hold = a >= cfg.under_mode_floor && metric < pick + band;
      end else begin
        on = metric >= pick;
        hold = metric >= pick - band;
      end
    end
    always_comb begin
      st_next = st_reg[s];
      el_next = el_reg;
      ext_next = ext_reg;
      sinc = 1'b0;
      tinc = 1'b0;
      rwe = 1'b0;
      pct = 8'(`PCT_FULL);
      if (i_tick) begin
        if (i_block[s]) begin
          st_next = prg_stage_pkg::ST_BLOCKED;
        end else begin
          case (st_reg[s])
            prg_stage_pkg::ST_START: begin
              if (!hold) begin
                st_next = prg_stage_pkg::ST_IDLE;
                rwe = 1'b1;
                pct = (cfg.delay_ticks == 16'h0000) ? 8'(`PCT_FULL) :
                      8'((24'(el_reg) * 24'(`PCT_FULL)) /
                         24'(cfg.delay_ticks));
              end else begin
                el_next = el_reg + 16'h0001;
                if (el_next >= cfg.delay_ticks) begin
                  st_next = prg_stage_pkg::ST_TRIP;
                  tinc = 1'b1;
                  rwe = 1'b1;
                end
              end
            end
            prg_stage_pkg::ST_TRIP: begin
              if (!hold) begin
                st_next = prg_stage_pkg::ST_IDLE;
              end
            end
            default: begin
              if (on) begin
                st_next = prg_stage_pkg::ST_START;
                sinc = 1'b1;
                el_next = 16'h0000;
                ext_next = metric[15:0];
              end else begin
                st_next = prg_stage_pkg::ST_IDLE;
              end
            end
          endcase
          // fault value is the worst seen: lowest in under mode
          if (st_reg[s] == prg_stage_pkg::ST_START ||
              st_reg[s] == prg_stage_pkg::ST_TRIP) begin
            if (cfg.mode == prg_stage_pkg::CMP_UNDER ? a < ext_reg
                : metric > $signed({2'b00, ext_reg})) begin
              ext_next = metric[15:0];
            end
          end
        end
      end
      if (wsel && so == `A_STATUS && force_reg &&
          i_hwdata[1]) begin
        st_next = prg_stage_pkg::stage_state_t'(i_hwdata[1:0]);
      end
      // an event in the clearing cycle still counts
      sc_next = ((wsel && so == `A_START_CNT) ? 32'h0000_0000 : sc_reg[s])
                + {31'h0000_0000, sinc};
      tc_next = ((wsel && so == `A_TRIP_CNT) ? 32'h0000_0000 : tc_reg[s])
                + {31'h0000_0000, tinc};
    end
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        st_reg[s] <= prg_stage_pkg::ST_IDLE;
        el_reg <= 16'h0000;
        ext_reg <= 16'h0000;
        sc_reg[s] <= 32'h0000_0000;
        tc_reg[s] <= 32'h0000_0000;
        wp_reg <= 3'b000;
      end else begin
        st_reg[s] <= st_next;
        el_reg <= el_next;
        ext_reg <= ext_next;
        sc_reg[s] <= sc_next;
        tc_reg[s] <= tc_next;
        if (rwe) begin
          // ring of eight, oldest overwritten
          rec_m[s][wp_reg] <= '{i_date, i_tod_ms, ext_next, pct,
                                grp_reg};
          wp_reg <= wp_reg + 3'b001;
        end
      end
    end
    assign o_start[s] = st_reg[s] == prg_stage_pkg::ST_START;
    assign o_trip[s] = st_reg[s] == prg_stage_pkg::ST_TRIP;
  end
  // ==========================================================
  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    if (glb) begin
      if (so == `A_ACT_GROUP) begin
        rd_val = {24'h00_0000, 2'b00, alt_grp_reg, 2'b00, grp_reg};
      end else if (so == `A_GRP_SRC) begin
        rd_val = {25'h000_0000, src_reg, 1'b0, src_idx_reg};
      end else if (so == `A_FORCE) begin
        rd_val = {31'h0000_0000, force_reg};
      end
    end else if (so == `A_STATUS) begin
      rd_val = {30'h0000_0000, st_reg[sa]};
    end else if (so == `A_START_CNT) begin
      rd_val = sc_reg[sa];
    end else if (so == `A_TRIP_CNT) begin
      rd_val = tc_reg[sa];
    end else if (so == `A_LINK) begin
      rd_val = {24'h00_0000, link_reg[sa]};
    end else if (so == `A_VALUE) begin
      rd_val = {i_sig_b[16*sa +: 16], i_sig_a[16*sa +: 16]};
    end else if (so == `A_PICK_PRI) begin
      rd_val = 32'(set_m[sa][grp_reg].pickup) * 32'(scale_reg[sa]);
    end else if (so == `A_PRI_SCALE) begin
      rd_val = {16'h0000, scale_reg[sa]};
    end else if (so[7:6] == `F_SETTING) begin
      case (so[3:2])
        2'd0: rd_val = {16'h0000, set_m[sa][so[5:4]].hyst_pct, 6'h00,
                        set_m[sa][so[5:4]].mode};
        2'd1: rd_val = {16'h0000, set_m[sa][so[5:4]].pickup};
        2'd2: rd_val = {16'h0000, set_m[sa][so[5:4]].under_mode_floor};
        default: rd_val = {16'h0000, set_m[sa][so[5:4]].delay_ticks};
      endcase
    end else if (so[7] == `F_RECORD) begin
      case (so[3:2])
        2'd0: rd_val = rec_m[sa][so[6:4]].date;
        2'd1: rd_val = rec_m[sa][so[6:4]].tod_ms;
        2'd2: rd_val = {16'h0000, rec_m[sa][so[6:4]].value};
        default: rd_val = {22'h00_0000, rec_m[sa][so[6:4]].group,
                           rec_m[sa][so[6:4]].elapsed_delay_pct};
      endcase
    end
  end
endmodule : prg_stage

// file: core/prg_stage_consts.svh
// offsets, field positions, reset values and timing counts of the
// programmable compare stage; included by bare name
`ifndef PRG_STAGE_CONSTS_SVH
`define PRG_STAGE_CONSTS_SVH
// ==========================================================
// sizes
`define N_STAGE 4
`define N_GROUP 4
`define N_REC 8
// ==========================================================
// per-stage offsets, stage s at byte base s*0x100
`define A_STATUS 8'h00
`define A_START_CNT 8'h04
`define A_TRIP_CNT 8'h08
`define A_LINK 8'h0c
`define A_VALUE 8'h10
`define A_PICK_PRI 8'h14
`define A_PRI_SCALE 8'h18
`define F_SETTING 2'b01
`define F_RECORD 1'b1
// ==========================================================
// global offsets, bit 10 of the address set
`define A_ACT_GROUP 8'h00
`define A_GRP_SRC 8'h04
`define A_FORCE 8'h08
// ==========================================================
// field positions
`define HYST_LSB 8
`define ALT_GRP_LSB 4
`define SRC_KIND_LSB 4
// ==========================================================
// reset values
`define RST_PICKUP 16'h0100
`define RST_FLOOR 16'h0000
`define RST_DELAY 16'h000a
`define RST_HYST 8'h03
`define RST_SCALE 16'h0001
// ==========================================================
// timing
`define CLK_MHZ 250
`define MS_PER_S 1000
`define FORCE_TIME_S 300
`define MS_CYCLES (`CLK_MHZ * 1000)
`define FORCE_MS (`FORCE_TIME_S * `MS_PER_S)
`define PCT_FULL 100
`endif

// file: core/prg_stage_pkg.sv
// types of the programmable compare stage
// assumes the consts header carries all numbers
package prg_stage_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_BLOCKED = 2'b01, ST_START = 2'b10, ST_TRIP = 2'b11
  } stage_state_t;
  typedef enum logic [1:0] {
    CMP_OVER = 2'b00, CMP_UNDER = 2'b01, CMP_DIFF = 2'b10,
    CMP_MAGNITUDE_DIFFERENCE = 2'b11
  } cmp_mode_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_DIGITAL = 3'b001, SRC_VIRTUAL_IN = 3'b010,
    SRC_INDICATOR = 3'b011, SRC_VIRTUAL_OUT = 3'b100
  } group_src_t;
  typedef struct packed {
    cmp_mode_t mode;
    logic [7:0] hyst_pct;
    logic [15:0] pickup;
    logic [15:0] under_mode_floor;
    logic [15:0] delay_ticks;
  } group_setting_t;
  typedef struct packed {
    logic [31:0] date;
    logic [31:0] tod_ms;
    logic [15:0] value;
    logic [7:0] elapsed_delay_pct;
    logic [1:0] group;
  } fault_record_t;
endpackage : prg_stage_pkg

// file: verif/prg_stage_sva.sv
// checker of the programmable compare stage, bound to its top module
// assumes a single bus master with i_hready tied to o_hreadyout
module prg_stage_sva #(
  parameter int MS_CYCLES = 4,
  parameter int FORCE_MS = 5
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_tick,
  input wire logic [7:0] i_digital_input_n,
  input wire logic [7:0] i_virtual_input_n,
  input wire logic [7:0] i_indicator_signal_n,
  input wire logic [7:0] i_virtual_output_n,
  input wire logic [3:0] o_start,
  input wire logic [3:0] o_trip,
  input wire logic [1:0] o_active_group,
  input wire logic o_force
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FORCE_CYC = MS_CYCLES * FORCE_MS;
  logic taken;
  logic wr_reg;
  logic wr_next;
  int fcnt_reg;
  int fcnt_next;
  // ==========================================
  // helper: write data phase, force on-time
  assign taken = i_hsel && i_htrans[1] && i_hready;
  always_comb begin
    wr_next = wr_reg;
    if (taken) begin
      wr_next = i_hwrite;
    end else if (o_hreadyout) begin
      wr_next = 1'b0;
    end
    // any completed write may re-arm the flag, so counting restarts there
    fcnt_next = (o_force && !(wr_reg && o_hreadyout)) ? fcnt_reg + 1 : 0;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_reg <= 1'b0;
      fcnt_reg <= 0;
    end else begin
      wr_reg <= wr_next;
      fcnt_reg <= fcnt_next;
    end
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ==========================================
  // properties
  AST_RESP_OKAY: assert property (o_hresp == 1'b0)
    else $error("bus response is not okay");
  AST_ONE_WAIT: assert property (taken |=> !o_hreadyout ##1 o_hreadyout)
    else $error("data phase is not two cycles");
  AST_STATE_EXCL: assert property ((o_start & o_trip) == 4'h0)
    else $error("start and trip at once");
  AST_TICK_ONLY: assert property (
    (!i_tick && !o_force) |=> ($stable(o_start) && $stable(o_trip)))
    else $error("stage state moved without a tick");
  AST_TRIP_FROM_START: assert property (
    (!o_force && !$past(o_force)) |->
    ((o_trip & ~$past(o_trip) & ~$past(o_start)) == 4'h0))
    else $error("trip without preceding start");
  AST_FORCE_BY_WRITE: assert property (
    $rose(o_force) |-> $past(wr_reg))
    else $error("force flag rose without a write");
  AST_FORCE_EXPIRES: assert property (fcnt_reg <= FORCE_CYC + 2)
    else $error("force flag outlived its timeout");
  AST_GROUP_STEADY: assert property (
    (!wr_reg && $stable({i_digital_input_n, i_virtual_input_n,
      i_indicator_signal_n, i_virtual_output_n}))[*3]
    |-> $stable(o_active_group))
    else $error("active group moved without cause");
  AST_RESET_STATE: assert property ($fell(i_rst) |->
    (o_start == 4'h0 && o_trip == 4'h0 && !o_force && o_hreadyout
    && o_active_group == 2'h0))
    else $error("state after reset is wrong");
  cover property (o_trip[0]);
  cover property ($fell(o_force));
  cover property (o_active_group == 2'h1);
endmodule : prg_stage_sva

bind prg_stage prg_stage_sva #(
  .MS_CYCLES(MS_CYCLES),
  .FORCE_MS(FORCE_MS)
) u_prg_stage_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .i_tick(i_tick),
  .i_digital_input_n(i_digital_input_n),
  .i_virtual_input_n(i_virtual_input_n),
  .i_indicator_signal_n(i_indicator_signal_n),
  .i_virtual_output_n(i_virtual_output_n), .o_start(o_start),
  .o_trip(o_trip), .o_active_group(o_active_group), .o_force(o_force)
);

// file: verif/meas_source.sv
// measurement subsystem model: supervised values and the task tick
// assumes requested values come from the bench, synchronous to i_clk
module meas_source #(
  parameter int TICK_DIV = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [63:0] i_req_a,
  input wire logic [63:0] i_req_b,
  output logic o_tick,
  output logic [63:0] o_sig_a,
  output logic [63:0] o_sig_b
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_reg;
  // values refresh mid-interval so every tick sees settled signals
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= 0;
      o_tick <= 1'b0;
      o_sig_a <= 64'h0;
      o_sig_b <= 64'h0;
    end else begin
      cnt_reg <= (cnt_reg == TICK_DIV - 1) ? 0 : cnt_reg + 1;
      o_tick <= (cnt_reg == TICK_DIV - 2);
      if (cnt_reg == TICK_DIV / 2) begin
        o_sig_a <= i_req_a;
        o_sig_b <= i_req_b;
      end
    end
  end
endmodule : meas_source

// file: verif/tb.sv
// self-checking bench of the programmable compare stage over AHB-Lite
// assumes one master, the stage timed by the measurement model's tick
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [63:0] ra = 64'h0;
  logic [63:0] rb = 64'h0;
  logic [3:0] blk = 4'h0;
  logic [7:0] src [4] = '{default: 8'h00};
  logic hready, hresp, tick, frc;
  logic [31:0] hrdata, rd;
  logic [63:0] sig_a, sig_b;
  logic [3:0] start, trip;
  logic [1:0] grp;
  logic [1:0] tm [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  logic [15:0] ta [5] = '{16'h200, 16'h20, 16'h80, 16'h10, 16'h10};
  logic [4:0] te = 5'h15;
  int error_cnt = 0;
  int checks = 0;
  int k;
  initial begin
    forever #2 clk = ~clk;
  end
  meas_source u_meas_source (.i_clk(clk), .i_rst(rst), .i_req_a(ra),
    .i_req_b(rb), .o_tick(tick), .o_sig_a(sig_a), .o_sig_b(sig_b));
  prg_stage #(.MS_CYCLES(4), .FORCE_MS(5)) u_prg_stage (.i_clk(clk),
    .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_tick(tick), .i_sig_a(sig_a), .i_sig_b(sig_b),
    .i_block(blk), .i_digital_input_n(src[0]),
    .i_virtual_input_n(src[1]), .i_indicator_signal_n(src[2]),
    .i_virtual_output_n(src[3]), .i_date(32'h0a0b0c0d),
    .i_tod_ms(32'h01020304), .o_start(start), .o_trip(trip),
    .o_active_group(grp), .o_force(frc));
  // ==========================================
  // tasks
  task automatic test_done();
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  // one edge after the tick, so the new state is seen settled
  task automatic tk(input int n);
    repeat (n) begin
      do @(posedge clk); while (tick !== 1'b1);
    end
    @(posedge clk);
  endtask : tk
  // ==========================================
  // tests
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rc(12'h044, 32'h100);
    rc(12'h04c, 32'ha);
    rc(12'h040, 32'h300);
    rc(12'h004, 32'h0);
    wr(12'h018, 32'h5);
    rc(12'h014, 32'h500);
    wr(12'h014, 32'h0);
    rc(12'h014, 32'h500);
    wr(12'h31c, 32'h5a5a);
    rc(12'h31c, 32'h0);
    tk(1);
    ra <= 64'h200;
    tk(1);
    chk(32'(start), 32'h1);
    tk(2);
    ra <= 64'hfa;
    tk(1);
    chk(32'(start), 32'h1);
    ra <= 64'hf8;
    tk(1);
    chk(32'(start), 32'h0);
    rc(12'h08c, 32'h1e);
    rc(12'h088, 32'h200);
    rc(12'h080, 32'h0a0b0c0d);
    rc(12'h084, 32'h01020304);
    wr(12'h04c, 32'h3);
    tk(1);
    ra <= 64'h200;
    tk(1);
    chk(32'(start), 32'h1);
    tk(2);
    chk(32'(trip), 32'h0);
    tk(1);
    chk(32'(trip), 32'h1);
    rc(12'h000, 32'h3);
    rc(12'h004, 32'h2);
    rc(12'h008, 32'h1);
    rc(12'h09c, 32'h64);
    rc(12'h010, 32'h200);
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h0);
    rc(12'h004, 32'h0);
    rc(12'h008, 32'h0);
    ra <= 64'h0;
    wr(12'h348, 32'h40);
    for (k = 0; k < 5; k++) begin
      wr(12'h340, {16'h0, 8'h03, 6'h0, tm[k]});
      tk(1);
      ra <= {ta[k], 48'h0};
      rb <= tm[k][1] ? 64'h0200_0000_0000_0000 : 64'h0;
      tk(2);
      chk(32'(start[3]), 32'(te[k]));
      wr(12'h340, 32'h300);
      tk(1);
      ra <= 64'h0;
      rb <= 64'h0;
      tk(2);
    end
    wr(12'h100, 32'h2);
    rc(12'h100, 32'h0);
    wr(12'h408, 32'h1);
    tk(1);
    wr(12'h100, 32'h2);
    @(posedge clk);
    chk(32'(start), 32'h2);
    repeat (25) @(posedge clk);
    chk(32'(frc), 32'h0);
    blk <= 4'h2;
    tk(2);
    rc(12'h100, 32'h1);
    blk <= 4'h0;
    wr(12'h400, 32'h12);
    rc(12'h400, 32'h12);
    for (k = 0; k < 5; k++) begin
      wr(12'h404, 32'(k * 16 + 3));
      src[(k == 0) ? 0 : k - 1] <= 8'h08;
      repeat (3) @(posedge clk);
      chk(32'(grp), (k == 0) ? 32'h2 : 32'h1);
      src[(k == 0) ? 0 : k - 1] <= 8'h00;
      repeat (3) @(posedge clk);
      chk(32'(grp), 32'h2);
    end
    // a fault under a group other than the first proves the record field
    tk(1);
    ra <= 64'h200;
    tk(1);
    ra <= 64'h0;
    tk(1);
    rc(12'h0ac, 32'h200);
    rc(12'h0a8, 32'h200);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : tb
